// ===== hw/clmst_defines.vh
// Constants for the clock monitor and analog self-test control block.
// Notes on behaviour
// - Monitor enables only after power-on reset release
// - Monitor stays active in all normal states
// - Clock failure: standby, regulators off, core reinit, reset
// - Clock failure sets clock-lost status flag
// - Monitor recheck accepted in diagnostic or active only
// - Monitor test emulates failure; clock-lost reads set
// - Monitor test leaves oscillator frequency unchanged
// - Test checks comparators, clock monitor, trim CRC
// - Comparator test leaves monitored rails untouched
// - Test starts on power-up and reset entry
// - Controller may start test through enable bit
// - During test: supply monitoring suspended, drive enable low
// - One test run takes about 300 us
// - Running flag is one throughout a run
// - Failure in diagnostic goes safe, no MCU reset
// - Error flag latched until a later passing run
// - Failure in active sets error flag only
// - Core supply fault: reset low, drive low, standby
// - Current-limit indication reads high when rail disabled
// - Clock loss: reset low, drive low, standby
`ifndef CLMST_DEFINES_VH
`define CLMST_DEFINES_VH
`define CLMST_CLK_HZ 25000000
`define CLMST_RUN_TIME_NS 300000
`define CLMST_RUN_CYCLES ((`CLMST_RUN_TIME_NS / 1000) * (`CLMST_CLK_HZ / 1000000))
`define CLMST_MON_CYCLES 8
`define CLMST_ST_STANDBY 5'h01
`define CLMST_ST_RESET 5'h02
`define CLMST_ST_DIAG 5'h04
`define CLMST_ST_ACTIVE 5'h08
`define CLMST_ST_SAFE 5'h10
`define CLMST_STAT3_RUN_BIT 0
`define CLMST_STAT3_ERR_BIT 2
`endif

// ===== hw/clmst_sync.v
// Two-stage synchroniser for a vector of asynchronous levels.
`default_nettype none
module clmst_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// ===== hw/clmst_seq.v
// Analog self-test sequencer: timed run over three check phases.
`include "clmst_defines.vh"
`default_nettype none
module clmst_seq #(
  parameter RUN_CYCLES = `CLMST_RUN_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire start,
  input wire voltage_monitor_check_ok,
  input wire clk_mon_toggled,
  input wire trim_crc_ok,
  output reg running_reg,
  output reg done_reg,
  output reg pass_reg,
  output wire clk_mon_test
);
  localparam [1:0] PH_VOLTAGE_MONITOR = 2'h0;
  localparam [1:0] PH_CLK = 2'h1;
  localparam [1:0] PH_CRC = 2'h2;
  localparam [31:0] PHASE_LEN = RUN_CYCLES / 3;

  reg [31:0] count_reg;
  reg [1:0] phase_reg;
  reg fail_reg;

  // The clock-monitor phase only emulates a failure; the oscillator is never touched.
  assign clk_mon_test = running_reg && (phase_reg == PH_CLK);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      running_reg <= 1'b0;
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
      count_reg <= 32'h00000000;
      phase_reg <= PH_VOLTAGE_MONITOR;
      fail_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!running_reg)
      begin
        if (start)
        begin
          running_reg <= 1'b1;
          count_reg <= 32'h00000000;
          phase_reg <= PH_VOLTAGE_MONITOR;
          fail_reg <= 1'b0;
        end
      end
      else
      begin
        count_reg <= count_reg + 32'h00000001;
        if (count_reg == PHASE_LEN - 32'h00000001 || count_reg == 2 * PHASE_LEN - 32'h00000001)
        begin
          // Comparator and clock-monitor verdicts are sampled at their phase end.
          if (phase_reg == PH_VOLTAGE_MONITOR)
            fail_reg <= fail_reg | ~voltage_monitor_check_ok;
          else
            fail_reg <= fail_reg | ~clk_mon_toggled;
          phase_reg <= phase_reg + 2'h1;
        end
        if (count_reg == RUN_CYCLES - 1)
        begin
          running_reg <= 1'b0;
          done_reg <= 1'b1;
          pass_reg <= ~(fail_reg | ~trim_crc_ok);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/clmst_top.v
// Top level of the clock-loss monitor and analog self-test control block.
`include "clmst_defines.vh"
`default_nettype none
module clmst_top #(
  parameter RUN_CYCLES = `CLMST_RUN_CYCLES,
  parameter MON_CYCLES = `CLMST_MON_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire power_on_reset_n,
  input wire osc_fail,
  input wire core_supply_undervolt_n,
  input wire core_supply_overvolt,
  input wire supply_fault,
  input wire voltage_monitor_check_ok,
  input wire trim_crc_ok,
  input wire can_rail_current_limit,
  input wire can_rail_enable,
  input wire analog_test_enable,
  input wire go_active,
  input wire go_diag,
  input wire enter_reset,
  input wire reset_done,
  output reg [4:0] state_reg,
  output reg mcu_reset_n,
  output reg drive_enable_out,
  output reg regulators_enable,
  output reg core_reinit,
  output reg clock_lost_flag,
  output reg analog_test_running,
  output reg analog_test_error,
  output reg supply_monitor_enable,
  output reg clock_monitor_enable,
  output reg can_rail_cl_observed,
  output wire clk_mon_test
);
  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  wire [8:0] sync_vec;
  clmst_sync #(
    .WIDTH(9)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({power_on_reset_n, osc_fail, core_supply_undervolt_n, core_supply_overvolt,
      supply_fault, voltage_monitor_check_ok, trim_crc_ok, can_rail_current_limit, can_rail_enable}),
    .sync_out(sync_vec)
  );
  wire por_n_s = sync_vec[8];
  wire osc_fail_s = sync_vec[7];
  wire uv_n_s = sync_vec[6];
  wire ov_s = sync_vec[5];
  wire sup_fault_s = sync_vec[4];
  wire voltage_monitor_ok_s = sync_vec[3];
  wire crc_ok_s = sync_vec[2];
  wire cl_s = sync_vec[1];
  wire en_s = sync_vec[0];

  // ----------------------------------------------------------------
  // Clock-loss monitor
  // ----------------------------------------------------------------
  reg por_seen_reg;
  reg osc_prev_reg;
  reg [3:0] mon_cnt_reg;
  reg mon_toggled_reg;
  reg [2:0] mon_mask_reg;
  wire seq_running;
  wire seq_done;
  wire seq_pass;
  // The emulated failure still drains out of the synchroniser after the test ends, so it stays masked.
  wire clock_loss = clock_monitor_enable && osc_fail_s && !clk_mon_test && !(|mon_mask_reg);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      por_seen_reg <= 1'b0;
      clock_monitor_enable <= 1'b0;
      osc_prev_reg <= 1'b0;
      mon_cnt_reg <= 4'h0;
      mon_toggled_reg <= 1'b0;
      mon_mask_reg <= 3'h0;
    end
    else
    begin
      por_seen_reg <= por_n_s;
      mon_mask_reg <= {mon_mask_reg[1:0], clk_mon_test};
      // Enabled once the power-on reset is released and kept on in every state.
      clock_monitor_enable <= por_seen_reg;
      osc_prev_reg <= osc_fail_s;
      if (!clk_mon_test)
      begin
        mon_cnt_reg <= 4'h0;
        mon_toggled_reg <= 1'b0;
      end
      else if (osc_fail_s != osc_prev_reg)
      begin
        // Emulated failure must toggle the monitor output often enough.
        if (mon_cnt_reg == MON_CYCLES[3:0] - 4'h1)
          mon_toggled_reg <= 1'b1;
        else
          mon_cnt_reg <= mon_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-test request and sequencer
  // ----------------------------------------------------------------
  reg en_prev_reg;
  reg start_reg;
  wire in_diag_or_active = (state_reg == `CLMST_ST_DIAG) || (state_reg == `CLMST_ST_ACTIVE);
  wire mcu_req = analog_test_enable && !en_prev_reg && in_diag_or_active;
  reg [4:0] state_next;
  // Every entry into the reset state starts a run, whatever caused it, unless a run is already in progress.
  wire reset_entry = (state_reg != `CLMST_ST_RESET) && (state_next == `CLMST_ST_RESET);
  wire power_up = por_seen_reg && !clock_monitor_enable;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_prev_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      en_prev_reg <= analog_test_enable;
      // Requests during a run are dropped, never restart it.
      start_reg <= (mcu_req || reset_entry || power_up) && !seq_running && !start_reg;
    end
  end

  clmst_seq #(
    .RUN_CYCLES(RUN_CYCLES)
  ) u_seq (
    .clk(clk),
    .resetn(resetn),
    .start(start_reg),
    .voltage_monitor_check_ok(voltage_monitor_ok_s),
    .clk_mon_toggled(mon_toggled_reg),
    .trim_crc_ok(crc_ok_s),
    .running_reg(seq_running),
    .done_reg(seq_done),
    .pass_reg(seq_pass),
    .clk_mon_test(clk_mon_test)
  );

  // ----------------------------------------------------------------
  // Device state
  // ----------------------------------------------------------------
  wire core_fault = !uv_n_s || ov_s;
  wire sup_fault_live = sup_fault_s && !seq_running;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `CLMST_ST_STANDBY:
        if (por_seen_reg && !core_fault)
          state_next = `CLMST_ST_RESET;
      `CLMST_ST_RESET:
        if (reset_done && !seq_running)
          state_next = `CLMST_ST_DIAG;
      `CLMST_ST_DIAG:
        if (seq_done && !seq_pass)
          state_next = `CLMST_ST_SAFE;
        else if (go_active && !seq_running)
          state_next = `CLMST_ST_ACTIVE;
      `CLMST_ST_ACTIVE:
        // A failed run here changes no state.
        if (enter_reset || sup_fault_live)
          state_next = `CLMST_ST_RESET;
      `CLMST_ST_SAFE:
        if (go_diag)
          state_next = `CLMST_ST_DIAG;
      default:
        state_next = `CLMST_ST_STANDBY;
    endcase
    if ((state_reg != `CLMST_ST_STANDBY) && enter_reset && state_next != `CLMST_ST_ACTIVE)
      state_next = `CLMST_ST_RESET;
    if (clock_loss || core_fault)
      state_next = `CLMST_ST_STANDBY;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= `CLMST_ST_STANDBY;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs and status flags
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mcu_reset_n <= 1'b0;
      drive_enable_out <= 1'b0;
      regulators_enable <= 1'b0;
      core_reinit <= 1'b0;
      clock_lost_flag <= 1'b0;
      analog_test_running <= 1'b0;
      analog_test_error <= 1'b0;
      supply_monitor_enable <= 1'b0;
      can_rail_cl_observed <= 1'b1;
    end
    else
    begin
      // Reset stays released through a safe-state entry after a failed run.
      mcu_reset_n <= !(clock_loss || core_fault) &&
        (state_next != `CLMST_ST_STANDBY) && (state_next != `CLMST_ST_RESET);
      drive_enable_out <= !(clock_loss || core_fault) && (state_next == `CLMST_ST_ACTIVE) &&
        !seq_running && !start_reg;
      regulators_enable <= !clock_loss && (state_next != `CLMST_ST_STANDBY);
      core_reinit <= clock_loss;
      supply_monitor_enable <= !seq_running && !start_reg;
      analog_test_running <= seq_running;
      if (clock_loss || clk_mon_test)
        clock_lost_flag <= 1'b1;
      else if (state_reg == `CLMST_ST_RESET)
        clock_lost_flag <= 1'b0;
      if (seq_done)
        analog_test_error <= !seq_pass;
      can_rail_cl_observed <= en_s ? cl_s : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/clmst_props.sv
// Concurrent checks on the ports of the clock monitor and self-test block.
`include "clmst_defines.vh"
`default_nettype none
module clmst_props #(
  parameter RUN_CYCLES = 30
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic power_on_reset_n,
  input wire logic osc_fail,
  input wire logic can_rail_enable,
  input wire logic [4:0] state_reg,
  input wire logic mcu_reset_n,
  input wire logic drive_enable_out,
  input wire logic regulators_enable,
  input wire logic clock_lost_flag,
  input wire logic analog_test_running,
  input wire logic analog_test_error,
  input wire logic supply_monitor_enable,
  input wire logic clock_monitor_enable,
  input wire logic can_rail_cl_observed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  int run_cnt;
  always @(posedge clk or negedge resetn)
    if (!resetn)
      run_cnt <= 0;
    else
      run_cnt <= analog_test_running ? run_cnt + 1 : 0;
  sequence s_err_set;
    $rose(analog_test_error);
  endsequence
  a_monitor_por_gate: assert property ((!power_on_reset_n)[*5] |-> !clock_monitor_enable)
    else $error("clock monitor enabled under power-on reset");
  a_monitor_stays_on: assert property (power_on_reset_n[*6] |-> clock_monitor_enable)
    else $error("clock monitor not active");
  a_run_drive_low: assert property (analog_test_running |-> !drive_enable_out)
    else $error("drive enable high during self-test");
  a_run_supmon_off: assert property (analog_test_running |-> !supply_monitor_enable)
    else $error("supply monitoring active during self-test");
  a_run_length: assert property ($fell(analog_test_running) |-> run_cnt >= RUN_CYCLES && run_cnt <= RUN_CYCLES + 2)
    else $error("self-test run length wrong");
  a_run_bounded: assert property (run_cnt <= RUN_CYCLES + 2)
    else $error("self-test running too long");
  a_error_latched: assert property ($changed(analog_test_error) |->
    analog_test_running || $past(analog_test_running) || state_reg == `CLMST_ST_STANDBY)
    else $error("error flag changed outside a run");
  a_diag_fail_safe: assert property (s_err_set ##0 $past(state_reg) == `CLMST_ST_DIAG |->
    ##[0:3] state_reg == `CLMST_ST_SAFE && mcu_reset_n)
    else $error("failed test in diagnostic did not reach safe");
  a_active_fail_stay: assert property (s_err_set ##0 $past(state_reg) == `CLMST_ST_ACTIVE |->
    (state_reg == `CLMST_ST_ACTIVE)[*4])
    else $error("failed test in active changed state");
  a_clock_loss_react: assert property ((clock_monitor_enable && !analog_test_running && osc_fail)[*4] |->
    ##[0:3] !mcu_reset_n && !drive_enable_out && !regulators_enable && clock_lost_flag)
    else $error("clock loss reaction missing");
  a_cl_disabled_high: assert property ((!can_rail_enable)[*5] |-> can_rail_cl_observed)
    else $error("current-limit indication low with rail disabled");
endmodule
bind clmst_top clmst_props #(.RUN_CYCLES(RUN_CYCLES)) i_props (.clk, .resetn, .power_on_reset_n, .osc_fail,
  .can_rail_enable, .state_reg, .mcu_reset_n, .drive_enable_out, .regulators_enable, .clock_lost_flag,
  .analog_test_running, .analog_test_error, .supply_monitor_enable, .clock_monitor_enable, .can_rail_cl_observed);
`default_nettype wire

// ===== testbench/clmst_mcu.sv
// Controller-side model that raises state and self-test requests.
`default_nettype none
module clmst_mcu (
  input wire logic clk,
  output var logic analog_test_enable,
  output var logic go_active,
  output var logic go_diag,
  output var logic enter_reset,
  output var logic reset_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {analog_test_enable, go_active, go_diag, enter_reset, reset_done} = 5'h00;
  // Raises one request for a single cycle: 0 test, 1 active, 2 diag, 3 reset, 4 reset done.
  task automatic req(input int which);
    @(posedge clk);
    #1;
    case (which)
      0: analog_test_enable = 1'b1;
      1: go_active = 1'b1;
      2: go_diag = 1'b1;
      3: enter_reset = 1'b1;
      default: reset_done = 1'b1;
    endcase
    @(posedge clk);
    #1;
    {analog_test_enable, go_active, go_diag, enter_reset, reset_done} = 5'h00;
  endtask
endmodule
`default_nettype wire

// ===== testbench/clock_monitor_analog_self_test_tb.sv
// Self-checking bench for the clock monitor and self-test control block.
`include "clmst_defines.vh"
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module clock_monitor_analog_self_test_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RUN = 60;
  logic clk = 0, resetn = 0, power_on_reset_n = 0, osc_stuck = 0, osc_emul = 0;
  logic uv_n = 1, ov = 0, cr_en = 1, crc_ok = 1, sup_flt = 0, voltage_monitor_ok = 1, cr_cl = 0;
  wire logic ate, ga, gd, er, rd, rst_n, drv, regs, reinit, lost, running, err, smon, cmon, clo, cmt;
  wire logic [4:0] state_reg;
  wire logic osc_fail = osc_stuck | osc_emul;
  int errors = 0, n_compared = 0, i;
  always #20 clk = ~clk;
  // The emulated monitor output toggles while the monitor self-test is engaged.
  always @(posedge clk) osc_emul <= cmt ? ~osc_emul : 1'b0;
  clmst_mcu i_mcu (.clk(clk), .analog_test_enable(ate), .go_active(ga), .go_diag(gd), .enter_reset(er),
    .reset_done(rd));
  clmst_top #(.RUN_CYCLES(RUN), .MON_CYCLES(8)) i_dut (.clk(clk), .resetn(resetn),
    .power_on_reset_n(power_on_reset_n), .osc_fail(osc_fail), .core_supply_undervolt_n(uv_n),
    .core_supply_overvolt(ov), .supply_fault(sup_flt), .voltage_monitor_check_ok(voltage_monitor_ok), .trim_crc_ok(crc_ok),
    .can_rail_current_limit(cr_cl), .can_rail_enable(cr_en), .analog_test_enable(ate), .go_active(ga),
    .go_diag(gd), .enter_reset(er), .reset_done(rd), .state_reg(state_reg), .mcu_reset_n(rst_n),
    .drive_enable_out(drv), .regulators_enable(regs), .core_reinit(reinit), .clock_lost_flag(lost),
    .analog_test_running(running), .analog_test_error(err), .supply_monitor_enable(smon),
    .clock_monitor_enable(cmon), .can_rail_cl_observed(clo), .clk_mon_test(cmt));
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_state(input logic [4:0] st);
    for (int k = 0; k < 40 && state_reg !== st; k++) tick;
    `CHK("state", st, state_reg)
  endtask
  task automatic run_test(input logic exp_err, input logic dup);
    for (int k = 0; k < 20 && running !== 1'b1; k++) tick;
    `CHK("running", 1'b1, running)
    `CHK("drive_run", 1'b0, drv)
    `CHK("supmon_run", 1'b0, smon)
    if (dup)
      i_mcu.req(0);
    for (int k = 0; k < RUN && cmt !== 1'b1; k++) tick;
    repeat (4) tick;
    `CHK("lost_in_test", 1'b1, lost)
    for (int k = 0; k < RUN + 20 && running !== 1'b0; k++) tick;
    `CHK("running_end", 1'b0, running)
    `CHK("error", exp_err, err)
  endtask
  task automatic to_diag;
    i_mcu.req(3);
    run_test(1'b0, 1'b0);
    i_mcu.req(4);
    wait_state(`CLMST_ST_DIAG);
  endtask
  initial begin
    #(400us);
    errors++;
    conclude;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    resetn = 1;
    tick;
    power_on_reset_n = 1;
    run_test(1'b0, 1'b0);
    i_mcu.req(4);
    wait_state(`CLMST_ST_DIAG);
    crc_ok = 0;
    i_mcu.req(0);
    run_test(1'b1, 1'b1);
    wait_state(`CLMST_ST_SAFE);
    `CHK("reset_n_safe", 1'b1, rst_n)
    `CHK("error_held", 1'b1, err)
    crc_ok = 1;
    to_diag;
    i_mcu.req(1);
    wait_state(`CLMST_ST_ACTIVE);
    voltage_monitor_ok = 0;
    i_mcu.req(0);
    run_test(1'b1, 1'b0);
    `CHK("state_active", `CLMST_ST_ACTIVE, state_reg)
    voltage_monitor_ok = 1;
    cr_en = 0;
    repeat (5) tick;
    `CHK("cl_off", 1'b1, clo)
    cr_en = 1;
    repeat (5) tick;
    `CHK("cl_on", 1'b0, clo)
    cr_cl = 1;
    repeat (5) tick;
    `CHK("cl_pass", 1'b1, clo)
    sup_flt = 1;
    wait_state(`CLMST_ST_RESET);
    run_test(1'b0, 1'b0);
    sup_flt = 0;
    i_mcu.req(4);
    wait_state(`CLMST_ST_DIAG);
    for (i = 0; i < 2; i++)
    begin
      to_diag;
      {uv_n, ov} = i ? 2'b11 : 2'b00;
      wait_state(`CLMST_ST_STANDBY);
      `CHK("reset_n_supply", 1'b0, rst_n)
      `CHK("drive_supply", 1'b0, drv)
      {uv_n, ov} = 2'b10;
    end
    to_diag;
    i_mcu.req(1);
    wait_state(`CLMST_ST_ACTIVE);
    osc_stuck = 1;
    wait_state(`CLMST_ST_STANDBY);
    `CHK("lost_flag", 1'b1, lost)
    `CHK("regulators", 1'b0, regs)
    `CHK("reset_n_clock", 1'b0, rst_n)
    `CHK("core_reinit", 1'b1, reinit)
    `CHK("monitor_on", 1'b1, cmon)
    osc_stuck = 0;
    conclude;
  end
endmodule
`default_nettype wire
